// ===== src/mmap_map.svh
`ifndef MMAP_MAP_SVH
`define MMAP_MAP_SVH
// ********************************************
// Register indices (byte address = index * 4)
// ********************************************
`define IDX_SIZE_READBACK 8'h1d
`define IDX_PAGE_SELECT 8'h30
`define RB_ROM_LSB 6
`define RB_PAG_LSB 0
`define PAGE_RST_ALL 6'h00
`define PAGE_RST_SPECIAL 6'h3c
// ********************************************
// Address map
// ********************************************
`define WIN_TOP 2'b10
`define LOW_TOP 2'b00
`define HIGH_TOP 2'b11
`define BDM_TOP 8'hff
`define ROM_SZ_NONE 2'b00
`define ROM_SZ_16K 2'b01
`define ROM_SZ_48K 2'b10
`define ROM_SZ_64K 2'b11
`define PART_128K 2'b00
`define PART_256K 2'b01
`define PART_512K 2'b10
`define PART_FIRST_128K 6'h38
`define PART_FIRST_256K 6'h30
`define PART_FIRST_512K 6'h20
// ********************************************
// Register block offsets
// ********************************************
`define OFF_PORT_A 10'h000
`define OFF_PORT_B 10'h001
`define OFF_DIR_A 10'h002
`define OFF_DIR_B 10'h003
`define OFF_PORT_E 10'h008
`define OFF_DIR_E 10'h009
`define OFF_PORT_K 10'h032
`define OFF_DIR_K 10'h033
`define OFF_SIZE_RB 10'h01d
`define OFF_PAGE 10'h030
`define PERIPH_SPAN 10'h010
`endif

// ===== src/mmap_pkg.sv
package mmap_pkg;
    typedef enum logic [2:0] {
        MD_SINGLE = 3'h0,
        MD_EXPANDED = 3'h1,
        MD_EMULATION = 3'h2,
        MD_SP_SINGLE = 3'h4,
        MD_SP_TEST = 3'h5,
        MD_SP_PERIPH = 3'h6
    } mode_t;
    typedef enum logic [1:0] {
        BS_IDLE = 2'b01,
        BS_ACK = 2'b10
    } bus_state_t;
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] mask;
    } window_t;
    typedef struct packed {
        logic background_debug_space;
        logic regs;
        logic ram;
        logic eep;
        logic flash;
        logic ext;
    } select_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic swap;
    } cpu_req_t;
    typedef struct packed {
        logic [15:0] background_debug_space;
        logic [15:0] regs;
        logic [15:0] ram;
        logic [15:0] eep;
        logic [15:0] flash;
        logic [15:0] ext;
    } src_rdata_t;
    typedef struct packed {
        bus_state_t bus;
        logic [7:0] rdata;
        logic [5:0] page;
        logic [1:0] rom_meta;
        logic [1:0] rom_sw;
        logic [1:0] pag_meta;
        logic [1:0] pag_sw;
        select_t sel;
        logic ecs_n;
        logic xcs_n;
        logic [1:0] pk_pins;
        logic [1:0] pk_oe;
        logic [15:0] cpu_rdata;
        logic [15:0] out_addr;
        logic [15:0] out_wdata;
        logic out_write;
    } mmap_state_t;
endpackage

// ===== src/memory_map_decode_paging.sv
`include "mmap_map.svh"

// Summary of operation
// - Size readback readable; writes change nothing
// - Readback shows live size and partition switches
// - Size field: none, 16K, 48K, 64K
// - Partition field gives off/on chip split
// - Page register readable; write permission option
// - Page resets 0x00 or 0x3C by option
// - Six index bits pick 16K window page
// - Bus page write effective next cycle
// - Call/return path updates page directly
// - Mux read sources, steer outbound, swap bytes
// - Decode space using mode and mapping
// - Emulation and external chip selects produced
// - At most one internal select active
// - Priority debug, regs, RAM, EEPROM, flash, external
// - Page windows decode at flash priority, above external only
// - Expanded: unclaimed external; ports A,B removed
// - Expanded with port E enable: E removed
// - Peripheral mode removes first 16 locations
// - Emulation with port K enable: K removed
// - Port K bit 7 emulation select, low
// - Port K bit 6 external select, low
// - Window internal or external by partition
module memory_map_decode_paging #(
    parameter logic WRITE_SPECIAL_ONLY = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [1:0] rom_size_switches_i,
    input wire logic [1:0] paging_partition_switches_i,
    input wire mmap_pkg::mode_t mode_i,
    input wire logic port_e_emulation_enable_i,
    input wire logic port_k_emulation_enable_i,
    input wire logic background_debug_space_i,
    input wire logic [5:0] register_block_position_i,
    input wire logic ram_enable_i,
    input wire mmap_pkg::window_t ram_window_i,
    input wire logic eep_enable_i,
    input wire mmap_pkg::window_t eep_window_i,
    input wire logic rom_enable_i,
    input wire mmap_pkg::cpu_req_t cpu_req_i,
    input wire mmap_pkg::src_rdata_t src_rdata_i,
    input wire logic call_page_we_i,
    input wire logic [5:0] call_page_data_i,
    input wire logic [1:0] port_k_gpio_i,
    input wire logic [1:0] port_k_gpio_oe_i,
    output logic [15:0] cpu_rdata_o,
    output logic [15:0] out_addr_o,
    output logic [15:0] out_wdata_o,
    output logic out_write_o,
    output mmap_pkg::select_t select_o,
    output logic [5:0] page_index_bits_o,
    output logic emulation_chip_select_n_o,
    output logic external_chip_select_n_o,
    output logic [1:0] port_k_pins_o,
    output logic [1:0] port_k_oe_o
);

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic page_internal(
        input logic [5:0] page,
        input logic [1:0] part
    );
        logic r;
        r = 1'b1;
        unique case (part)
            `PART_128K: r = (page >= `PART_FIRST_128K);
            `PART_256K: r = (page >= `PART_FIRST_256K);
            `PART_512K: r = (page >= `PART_FIRST_512K);
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    // Fixed (unpaged) flash ranges outside the program window
    function automatic logic rom_fixed_hit(
        input logic [1:0] top,
        input logic [1:0] rom_sw
    );
        logic r;
        r = 1'b0;
        unique case (rom_sw)
            `ROM_SZ_NONE: r = 1'b0;
            `ROM_SZ_16K: r = (top == `HIGH_TOP);
            `ROM_SZ_48K: r = (top != `LOW_TOP);
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic win_hit(
        input logic [15:0] addr,
        input mmap_pkg::window_t w
    );
        return (addr & w.mask) == w.base;
    endfunction

    // ********************************************
    // Mode decode
    // ********************************************
    // Unused mode codes fall back to single-chip behaviour
    function automatic logic mode_expanded(
        input mmap_pkg::mode_t m
    );
        logic r;
        r = 1'b0;
        unique case (m)
            mmap_pkg::MD_SINGLE: r = 1'b0;
            mmap_pkg::MD_EXPANDED: r = 1'b1;
            mmap_pkg::MD_EMULATION: r = 1'b1;
            mmap_pkg::MD_SP_SINGLE: r = 1'b0;
            mmap_pkg::MD_SP_TEST: r = 1'b1;
            mmap_pkg::MD_SP_PERIPH: r = 1'b0;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Special modes also unlock a page register kept write protected
    function automatic logic mode_special(
        input mmap_pkg::mode_t m
    );
        logic r;
        r = 1'b0;
        unique case (m)
            mmap_pkg::MD_SINGLE: r = 1'b0;
            mmap_pkg::MD_EXPANDED: r = 1'b0;
            mmap_pkg::MD_EMULATION: r = 1'b0;
            mmap_pkg::MD_SP_SINGLE: r = 1'b1;
            mmap_pkg::MD_SP_TEST: r = 1'b1;
            mmap_pkg::MD_SP_PERIPH: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Removed locations fall to the external bus in expanded modes (no select in other modes), never to registers
    function automatic logic loc_removed(
        input logic [9:0] off,
        input mmap_pkg::mode_t m,
        input logic pe_en,
        input logic pk_en
    );
        logic r;
        r = 1'b0;
        if (mode_expanded(m) && (off == `OFF_PORT_A ||
            off == `OFF_PORT_B || off == `OFF_DIR_A ||
            off == `OFF_DIR_B)) begin
            r = 1'b1;
        end
        if (mode_expanded(m) && pe_en &&
            (off == `OFF_PORT_E || off == `OFF_DIR_E)) begin
            r = 1'b1;
        end
        if (m == mmap_pkg::MD_SP_PERIPH && off < `PERIPH_SPAN) begin
            r = 1'b1;
        end
        if (m == mmap_pkg::MD_EMULATION && pk_en &&
            (off == `OFF_PORT_K || off == `OFF_DIR_K)) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // ********************************************
    // State
    // ********************************************
    localparam logic [5:0] PAGE_RESET = WRITE_SPECIAL_ONLY ?
        `PAGE_RST_SPECIAL : `PAGE_RST_ALL;

    localparam mmap_pkg::mmap_state_t RESET_ST = '{
        bus: mmap_pkg::BS_IDLE,
        rdata: 8'h00,
        page: PAGE_RESET,
        rom_meta: 2'h0,
        rom_sw: 2'h0,
        pag_meta: 2'h0,
        pag_sw: 2'h0,
        sel: '0,
        ecs_n: 1'b1,
        xcs_n: 1'b1,
        pk_pins: 2'h0,
        pk_oe: 2'h0,
        cpu_rdata: 16'h0000,
        out_addr: 16'h0000,
        out_wdata: 16'h0000,
        out_write: 1'b0
    };

    mmap_pkg::mmap_state_t st_reg;
    mmap_pkg::mmap_state_t st_next;

    logic expanded;
    logic emulation;
    logic special;
    logic [7:0] bus_idx;
    logic [7:0] readback;
    logic wr_ok;
    logic in_regs;
    logic [9:0] off;
    logic removed;
    logic in_win;
    logic flash_hit;
    logic emulation_chip_select;
    logic external_chip_select;
    mmap_pkg::select_t sel;
    logic [15:0] rd;

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        st_next = st_reg;
        // Switches are static, but still synchronised as pins
        st_next.rom_meta = rom_size_switches_i;
        st_next.rom_sw = st_reg.rom_meta;
        st_next.pag_meta = paging_partition_switches_i;
        st_next.pag_sw = st_reg.pag_meta;

        expanded = mode_expanded(mode_i);
        emulation = (mode_i == mmap_pkg::MD_EMULATION);
        special = mode_special(mode_i);
        wr_ok = !WRITE_SPECIAL_ONLY || special;

        readback = 8'h00;
        readback[`RB_ROM_LSB +: 2] = st_reg.rom_sw;
        readback[`RB_PAG_LSB +: 2] = st_reg.pag_sw;

        // Register bus slave: answer one cycle after request
        bus_idx = avs_address_i[9:2];
        unique case (st_reg.bus)
            mmap_pkg::BS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_next.bus = mmap_pkg::BS_ACK;
                    st_next.rdata = 8'h00;
                    if (bus_idx == `IDX_SIZE_READBACK) begin
                        st_next.rdata = readback;
                    end else if (bus_idx == `IDX_PAGE_SELECT) begin
                        st_next.rdata = {2'b00, st_reg.page};
                    end
                end
            end
            mmap_pkg::BS_ACK: begin
                st_next.bus = mmap_pkg::BS_IDLE;
                // Writes to the readback index fall through
                if (avs_write_i && avs_byteenable_i[0] && wr_ok &&
                    bus_idx == `IDX_PAGE_SELECT) begin
                    st_next.page = avs_writedata_i[5:0];
                end
            end
        endcase

        // Call/return path wins; the core never overlaps the two
        if (call_page_we_i) begin
            st_next.page = call_page_data_i;
        end

        // ********************************************
        // Address decode
        // ********************************************
        in_regs = cpu_req_i.addr[15:10] == register_block_position_i;
        off = cpu_req_i.addr[9:0];
        removed = loc_removed(off, mode_i, port_e_emulation_enable_i,
            port_k_emulation_enable_i);
        removed = removed && in_regs;

        // Window pages decode at the flash step, after debug, regs, RAM and EEPROM, so those stay visible
        in_win = cpu_req_i.addr[15:14] == `WIN_TOP;
        flash_hit = rom_enable_i && (in_win ?
            page_internal(st_reg.page, st_reg.pag_sw) :
            rom_fixed_hit(cpu_req_i.addr[15:14], st_reg.rom_sw));

        sel = '0;
        if (background_debug_space_i &&
            cpu_req_i.addr[15:8] == `BDM_TOP) begin
            sel.background_debug_space = 1'b1;
        end else if (in_regs && !removed) begin
            sel.regs = 1'b1;
        end else if (!in_regs && ram_enable_i &&
            win_hit(cpu_req_i.addr, ram_window_i)) begin
            sel.ram = 1'b1;
        end else if (!in_regs && eep_enable_i &&
            win_hit(cpu_req_i.addr, eep_window_i)) begin
            sel.eep = 1'b1;
        end else if (!in_regs && flash_hit) begin
            sel.flash = 1'b1;
        end else if (expanded) begin
            sel.ext = 1'b1;
        end
        st_next.sel = sel;

        // Chip selects toward the external bus
        emulation_chip_select = port_k_emulation_enable_i && emulation &&
            sel.flash;
        external_chip_select = port_k_emulation_enable_i && sel.ext &&
            !removed && !emulation_chip_select;
        st_next.ecs_n = !emulation_chip_select;
        st_next.xcs_n = !external_chip_select;
        if (port_k_emulation_enable_i) begin
            st_next.pk_pins = {!emulation_chip_select, !external_chip_select};
            st_next.pk_oe = 2'b11;
        end else begin
            st_next.pk_pins = port_k_gpio_i;
            st_next.pk_oe = port_k_gpio_oe_i;
        end

        // ********************************************
        // Bus control
        // ********************************************
        rd = 16'h0000;
        unique case (1'b1)
            sel.background_debug_space: rd = src_rdata_i.background_debug_space;
            sel.regs: begin
                if (off == `OFF_SIZE_RB) begin
                    rd = {8'h00, readback};
                end else if (off == `OFF_PAGE) begin
                    rd = {10'h000, st_reg.page};
                end else begin
                    rd = src_rdata_i.regs;
                end
            end
            sel.ram: rd = src_rdata_i.ram;
            sel.eep: rd = src_rdata_i.eep;
            sel.flash: rd = src_rdata_i.flash;
            sel.ext: rd = src_rdata_i.ext;
            default: rd = 16'h0000;
        endcase
        st_next.cpu_rdata = cpu_req_i.swap ?
            {rd[7:0], rd[15:8]} : rd;
        st_next.out_addr = cpu_req_i.addr;
        st_next.out_wdata = cpu_req_i.wdata;
        // Removed locations never write internal blocks
        st_next.out_write = cpu_req_i.write;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= RESET_ST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign avs_readdata_o = {24'h000000, st_reg.rdata};
    assign avs_waitrequest_o = st_reg.bus[0];
    assign cpu_rdata_o = st_reg.cpu_rdata;
    assign out_addr_o = st_reg.out_addr;
    assign out_wdata_o = st_reg.out_wdata;
    assign out_write_o = st_reg.out_write;
    assign select_o = st_reg.sel;
    assign page_index_bits_o = st_reg.page;
    assign emulation_chip_select_n_o = st_reg.ecs_n;
    assign external_chip_select_n_o = st_reg.xcs_n;
    assign port_k_pins_o = st_reg.pk_pins;
    assign port_k_oe_o = st_reg.pk_oe;

endmodule

// ===== sim/mmap_checker_sva.sv
module mmap_checker #(
    parameter logic WRITE_SPECIAL_ONLY = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] rom_size_switches_i,
    input wire logic [1:0] paging_partition_switches_i,
    input wire mmap_pkg::mode_t mode_i,
    input wire logic port_k_emulation_enable_i,
    input wire mmap_pkg::cpu_req_t cpu_req_i,
    input wire logic call_page_we_i,
    input wire logic [5:0] call_page_data_i,
    input wire logic [15:0] out_addr_o,
    input wire mmap_pkg::select_t select_o,
    input wire logic [5:0] page_index_bits_o,
    input wire logic emulation_chip_select_n_o,
    input wire logic external_chip_select_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic ans_rd;
    logic ans_wr;
    logic [7:0] idx;
    assign ans_rd = avs_read_i && !avs_waitrequest_o;
    assign ans_wr = avs_write_i && !avs_waitrequest_o;
    assign idx = avs_address_i[9:2];
    wait_once_a:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bad answer");
    page_read_a:
    assert property (ans_rd && idx == 8'h30
        |-> avs_readdata_o == {26'h0, page_index_bits_o})
        else $error("page rd");
    size_read_a:
    assert property (ans_rd && idx == 8'h1d |-> avs_readdata_o == {24'h0,
        $past(rom_size_switches_i, 3), 4'h0,
        $past(paging_partition_switches_i, 3)}) else $error("size rd");
    page_late_a:
    assert property (ans_wr && idx == 8'h30 && avs_byteenable_i[0]
        && !WRITE_SPECIAL_ONLY && !call_page_we_i && !$past(call_page_we_i)
        |-> $stable(page_index_bits_o) ##1
        page_index_bits_o == $past(avs_writedata_i[5:0]))
        else $error("page wr");
    size_ro_a:
    assert property (ans_wr && idx == 8'h1d && !call_page_we_i
        |=> $stable(page_index_bits_o)) else $error("size write took effect");
    call_path_a:
    assert property (call_page_we_i
        |=> page_index_bits_o == $past(call_page_data_i)) else $error("call");
    one_sel_a:
    assert property ($onehot0(select_o)) else $error("several selects");
    ecs_cause_a:
    assert property (!emulation_chip_select_n_o |-> select_o.flash
        && $past(mode_i) == mmap_pkg::MD_EMULATION
        && $past(port_k_emulation_enable_i)) else $error("ecs");
    xcs_cause_a:
    assert property (!external_chip_select_n_o |-> select_o.ext
        && emulation_chip_select_n_o && $past(port_k_emulation_enable_i))
        else $error("xcs");
    steer_addr_a:
    assert property ($past(nrst_i) |-> out_addr_o == $past(cpu_req_i.addr))
        else $error("out addr");
endmodule

bind memory_map_decode_paging mmap_checker #(
    .WRITE_SPECIAL_ONLY(WRITE_SPECIAL_ONLY)
) checker_i (.ref_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .rom_size_switches_i, .paging_partition_switches_i, .mode_i,
    .port_k_emulation_enable_i, .cpu_req_i, .call_page_we_i, .call_page_data_i,
    .out_addr_o, .select_o, .page_index_bits_o, .emulation_chip_select_n_o,
    .external_chip_select_n_o);

// ===== sim/src_model.sv
module src_model (
    output mmap_pkg::src_rdata_t src_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Distinct word per source so a wrong mux leg or swap shows at once
    assign src_rdata_o = {16'hb0d1, 16'h5e62, 16'ha3b4,
        16'hee05, 16'hf1a6, 16'hc8e7};
endmodule

// ===== sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] s_bdm = 6'h20, s_reg = 6'h10, s_ram = 6'h08;
    localparam logic [5:0] s_eep = 6'h04, s_fl = 6'h02, s_ext = 6'h01;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic avs_waitrequest_o, out_write_o;
    logic [1:0] rom_size_switches_i = 2'b11;
    logic [1:0] paging_partition_switches_i = 2'b00;
    mmap_pkg::mode_t mode_i = mmap_pkg::MD_SINGLE;
    logic port_e_emulation_enable_i = 1'b0, port_k_emulation_enable_i = 1'b0;
    logic background_debug_space_i = 1'b0, ram_enable_i = 1'b0;
    logic eep_enable_i = 1'b0, rom_enable_i = 1'b1, call_page_we_i = 1'b0;
    logic [5:0] register_block_position_i = 6'h00, call_page_data_i = 6'h00;
    mmap_pkg::window_t ram_window_i = {16'h0000, 16'hf000};
    mmap_pkg::window_t eep_window_i = {16'h0000, 16'hf000};
    mmap_pkg::cpu_req_t cpu_req_i = '0;
    mmap_pkg::src_rdata_t src_rdata_i;
    logic [1:0] port_k_gpio_i = 2'b10, port_k_gpio_oe_i = 2'b11;
    logic [15:0] cpu_rdata_o, out_addr_o, out_wdata_o;
    mmap_pkg::select_t select_o;
    logic [5:0] page_index_bits_o;
    logic emulation_chip_select_n_o, external_chip_select_n_o;
    logic [1:0] cs_n;
    logic [1:0] port_k_pins_o, port_k_oe_o;
    int err_count = 0;
    int n_checks = 0;

    memory_map_decode_paging #(.WRITE_SPECIAL_ONLY(1'b0)) uut (.ref_clk_i,
        .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .rom_size_switches_i, .paging_partition_switches_i, .mode_i,
        .port_e_emulation_enable_i, .port_k_emulation_enable_i,
        .background_debug_space_i, .register_block_position_i, .ram_enable_i,
        .ram_window_i, .eep_enable_i, .eep_window_i, .rom_enable_i, .cpu_req_i,
        .src_rdata_i, .call_page_we_i, .call_page_data_i, .port_k_gpio_i,
        .port_k_gpio_oe_i, .cpu_rdata_o, .out_addr_o, .out_wdata_o,
        .out_write_o, .select_o, .page_index_bits_o, .emulation_chip_select_n_o,
        .external_chip_select_n_o, .port_k_pins_o, .port_k_oe_o);
    src_model model (.src_rdata_o(src_rdata_i));
    assign cs_n = {emulation_chip_select_n_o, external_chip_select_n_o};

    always #50 ref_clk_i = ~ref_clk_i;

    // ********************************************
    // Bus and compare tasks
    // ********************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low; no latency assumed
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic dec(input logic [15:0] a, input logic [5:0] e);
        cpu_req_i <= {a, 16'h0, 1'b0, 1'b0};
        repeat (2) @(posedge ref_clk_i);
        chk({26'h0, select_o}, {26'h0, e});
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ********************************************
    // Tests
    // ********************************************
    initial begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        chk({26'h0, page_index_bits_o}, 32'h0);
        chk(cs_n, 2'b11);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rom_size_switches_i <= i[1:0];
            paging_partition_switches_i <= 2'(3 - i);
            repeat (6) @(posedge ref_clk_i);
            bus(1'b0, 8'h1d, 32'h0, 4'hf, rd);
            chk(rd, {24'h0, i[1:0], 4'h0, 2'(3 - i)});
        end
        bus(1'b1, 8'h1d, 32'hff, 4'hf, rd);
        bus(1'b0, 8'h1d, 32'h0, 4'hf, rd);
        chk(rd, 32'hc0);
        chk({26'h0, page_index_bits_o}, 32'h0);
        $display("test readback done");
        bus(1'b1, 8'h30, 32'hff, 4'hf, rd);
        bus(1'b0, 8'h30, 32'h0, 4'hf, rd);
        chk(rd, 32'h3f);
        bus(1'b1, 8'h30, 32'h05, 4'he, rd);
        bus(1'b0, 8'h30, 32'h0, 4'hf, rd);
        chk(rd, 32'h3f);
        bus(1'b0, 8'h55, 32'h0, 4'hf, rd);
        chk(rd, 32'h0);
        call_page_data_i <= 6'h15;
        call_page_we_i <= 1'b1;
        @(posedge ref_clk_i);
        call_page_we_i <= 1'b0;
        @(posedge ref_clk_i);
        chk({26'h0, page_index_bits_o}, 32'h15);
        $display("test page register done");
        mode_i <= mmap_pkg::MD_EXPANDED;
        for (int p = 0; p < 4; p++) begin
            paging_partition_switches_i <= p[1:0];
            bus(1'b1, 8'h30, 32'(6'(64 - (8 << p))), 4'hf, rd);
            dec(16'h8000, s_fl);
            if (p < 3) begin
                bus(1'b1, 8'h30, 32'(6'(63 - (8 << p))), 4'hf, rd);
                dec(16'hbfff, s_ext);
            end
        end
        $display("test page window done");
        mode_i <= mmap_pkg::MD_SINGLE;
        background_debug_space_i <= 1'b1;
        ram_enable_i <= 1'b1;
        eep_enable_i <= 1'b1;
        dec(16'hff10, s_bdm);
        dec(16'h0100, s_reg);
        dec(16'h0800, s_ram);
        ram_enable_i <= 1'b0;
        dec(16'h0800, s_eep);
        eep_enable_i <= 1'b0;
        dec(16'h0800, s_fl);
        rom_enable_i <= 1'b0;
        dec(16'h0800, 6'h00);
        mode_i <= mmap_pkg::MD_EXPANDED;
        dec(16'h0800, s_ext);
        dec(16'h0003, s_ext);
        dec(16'h0008, s_reg);
        port_e_emulation_enable_i <= 1'b1;
        dec(16'h0008, s_ext);
        mode_i <= mmap_pkg::MD_SP_PERIPH;
        // Peripheral mode has no external bus, so a removed location gets no select
        dec(16'h000f, 6'h00);
        dec(16'h0010, s_reg);
        $display("test decode done");
        mode_i <= mmap_pkg::MD_EMULATION;
        port_k_emulation_enable_i <= 1'b1;
        dec(16'h0032, s_ext);
        chk(external_chip_select_n_o, 1'b1);
        dec(16'h4000, s_ext);
        chk(cs_n, 2'b10);
        rom_enable_i <= 1'b1;
        dec(16'hc000, s_fl);
        chk({port_k_pins_o, port_k_oe_o}, 4'h7);
        port_k_emulation_enable_i <= 1'b0;
        dec(16'hc000, s_fl);
        chk({port_k_pins_o, port_k_oe_o}, 4'hb);
        $display("test chip selects done");
        cpu_req_i <= {16'hc123, 16'h5a3c, 1'b1, 1'b0};
        repeat (2) @(posedge ref_clk_i);
        chk({out_addr_o, out_wdata_o}, 32'hc1235a3c);
        chk(out_write_o, 1'b1);
        for (int s = 0; s < 2; s++) begin
            cpu_req_i <= {16'hc123, 16'h0, 1'b0, s[0]};
            repeat (2) @(posedge ref_clk_i);
            chk(cpu_rdata_o, (s == 0) ? 32'hf1a6 : 32'ha6f1);
        end
        $display("test bus steering done");
        summarize();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_count++;
        summarize();
    end
endmodule
